// *** hdl/rwd_watchdog_ctrl.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// (R1) writing one to the strobe bit reloads the countdown with the programmed timeout
// (R2) while the write-lock bit is one, writes to the six timeout bits are ignored
// (R3) host sets write-lock together with strobe to kick without changing timeout
// (R4) a write with write-lock zero stores the new timeout bits at write completion
// (R5) timeout equals the six-bit setting times the 31.25 ms tick
// (R6) alarm match sets alarm flag; drives interrupt only when alarm enable is one
// (R7) power-fail sets power-fail flag; drives interrupt only when its enable is one
// (R8) watchdog expiry sets its flag; drives interrupt only when watchdog enable is one; here the flag is also set only when it is one
module rwd_watchdog_ctrl
    import rwd_pkg::*;
#(
    parameter int TICK_CYCLES = WD_TICK_CYCLES
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // register port
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [REG_ADDR_W-1:0] reg_addr,
    input wire logic [REG_DATA_W-1:0] reg_wdata,
    output logic [REG_DATA_W-1:0] reg_rdata,
    // rtc events, same clock domain
    input wire logic alarm_match,
    input wire logic powerfail_event,
    input wire logic flags_clear,
    // status and interrupt
    output logic alarm_flag,
    output logic powerfail_flag,
    output logic watchdog_flag,
    output logic irq_out
);
    localparam int PRE_W = $clog2(TICK_CYCLES + 1);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);
    localparam logic [PRE_W-1:0] PRE_ZERO = '0;
    localparam logic [WD_TICKS_W-1:0] CNT_ZERO = '0;
    localparam logic [WD_TICKS_W-1:0] CNT_ONE = WD_TICKS_W'(1);

    // ----------------------------------------------------------------
    // register decode
    // ----------------------------------------------------------------
    logic [REG_DATA_W-1:0] irq_ctrl_r, irq_ctrl_nxt;
    logic timeout_write_lock_r, timeout_write_lock_nxt;
    logic [WD_TICKS_W-1:0] timeout_ticks_r, timeout_ticks_nxt;
    logic [REG_DATA_W-1:0] reg_rdata_r, reg_rdata_nxt;
    logic wr_wd, wr_ic, watchdog_strobe;
    logic watchdog_irq_enable, alarm_irq_enable, powerfail_irq_enable;

    assign wr_wd = reg_wr_en && (reg_addr == REG_WD_CTRL);
    assign wr_ic = reg_wr_en && (reg_addr == REG_IRQ_CTRL);
    assign watchdog_strobe = wr_wd && reg_wdata[WD_STROBE_BIT];
    assign watchdog_irq_enable = irq_ctrl_r[IC_WIE_BIT];
    assign alarm_irq_enable = irq_ctrl_r[IC_AIE_BIT];
    assign powerfail_irq_enable = irq_ctrl_r[IC_PFE_BIT];

    // register next values; the strobe bit is an action and never stored
    always_comb begin
        irq_ctrl_nxt = irq_ctrl_r;
        timeout_write_lock_nxt = timeout_write_lock_r;
        timeout_ticks_nxt = timeout_ticks_r;
        reg_rdata_nxt = reg_rdata_r;
        if (wr_ic) begin
            irq_ctrl_nxt = reg_wdata;
        end
        if (wr_wd) begin
            timeout_write_lock_nxt = reg_wdata[WD_LOCK_BIT];
            // the lock in this very write guards the timeout field
            if (!reg_wdata[WD_LOCK_BIT]) begin // R2 R4
                timeout_ticks_nxt = reg_wdata[WD_TICKS_MSB:0];
            end
        end
        if (reg_rd_en) begin
            case (reg_addr)
                REG_IRQ_CTRL: reg_rdata_nxt = irq_ctrl_r;
                REG_WD_CTRL: reg_rdata_nxt = {1'b0, timeout_write_lock_r, timeout_ticks_r};
                default: reg_rdata_nxt = '0; // unmapped reads as zero
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            irq_ctrl_r <= IRQ_CTRL_RST;
            timeout_write_lock_r <= WD_LOCK_RST;
            timeout_ticks_r <= WD_TICKS_RST;
            reg_rdata_r <= '0;
        end else begin
            irq_ctrl_r <= irq_ctrl_nxt;
            timeout_write_lock_r <= timeout_write_lock_nxt;
            timeout_ticks_r <= timeout_ticks_nxt;
            reg_rdata_r <= reg_rdata_nxt;
        end
    end

    // ----------------------------------------------------------------
    // watchdog countdown
    // ----------------------------------------------------------------
    logic [PRE_W-1:0] pre_r, pre_nxt;
    logic [WD_TICKS_W-1:0] wd_count_r, wd_count_nxt;
    logic tick, expire;

    // prescaler makes the 32 Hz tick; a strobe restarts it so the
    // first tick after a kick is a whole period away
    assign tick = (pre_r == PRE_LAST);
    assign expire = tick && !watchdog_strobe && (wd_count_r == CNT_ONE);

    always_comb begin
        pre_nxt = tick ? PRE_ZERO : pre_r + PRE_W'(1);
        wd_count_nxt = wd_count_r;
        if (watchdog_strobe) begin
            // a strobe in the same write as a new timeout starts from the new value
            pre_nxt = PRE_ZERO; // R1
            wd_count_nxt = timeout_ticks_nxt; // R1
        end else if (wd_count_r == CNT_ZERO) begin
            // idle until a nonzero timeout is programmed
            wd_count_nxt = timeout_ticks_r;
        end else if (tick) begin
            // one count per tick gives setting times 31.25 ms
            wd_count_nxt = (wd_count_r == CNT_ONE) ? timeout_ticks_r : wd_count_r - CNT_ONE; // R5
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pre_r <= PRE_ZERO;
            wd_count_r <= CNT_ZERO;
        end else begin
            pre_r <= pre_nxt;
            wd_count_r <= wd_count_nxt;
        end
    end

    // ----------------------------------------------------------------
    // flags and interrupt
    // ----------------------------------------------------------------
    logic alarm_flag_r, alarm_flag_nxt;
    logic powerfail_flag_r, powerfail_flag_nxt;
    logic watchdog_flag_r, watchdog_flag_nxt;
    logic irq_out_r, irq_out_nxt;

    // a new event in the clear cycle wins, so no event is lost
    always_comb begin
        alarm_flag_nxt = alarm_match || (alarm_flag_r && !flags_clear); // R6
        powerfail_flag_nxt = powerfail_event || (powerfail_flag_r && !flags_clear); // R7
        watchdog_flag_nxt = (expire && watchdog_irq_enable) || (watchdog_flag_r && !flags_clear); // R8
        // alarm and power-fail enables gate only the pin; the watchdog enable also gates its flag
        irq_out_nxt = (watchdog_irq_enable && watchdog_flag_r) // R8
            || (alarm_irq_enable && alarm_flag_r) // R6
            || (powerfail_irq_enable && powerfail_flag_r); // R7
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            alarm_flag_r <= 1'b0;
            powerfail_flag_r <= 1'b0;
            watchdog_flag_r <= 1'b0;
            irq_out_r <= 1'b0;
        end else begin
            alarm_flag_r <= alarm_flag_nxt;
            powerfail_flag_r <= powerfail_flag_nxt;
            watchdog_flag_r <= watchdog_flag_nxt;
            irq_out_r <= irq_out_nxt;
        end
    end

    assign reg_rdata = reg_rdata_r;
    assign alarm_flag = alarm_flag_r;
    assign powerfail_flag = powerfail_flag_r;
    assign watchdog_flag = watchdog_flag_r;
    assign irq_out = irq_out_r;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    // register side: the lock is stored on every watchdog write, the timeout only when unlocked
    chk_strobe_reload: assert property (watchdog_strobe |=> wd_count_r == timeout_ticks_r && pre_r == PRE_ZERO) // R1
        else $error("strobe did not reload the countdown");
    chk_lock_holds: assert property (wr_wd && reg_wdata[WD_LOCK_BIT] |=> $stable(timeout_ticks_r)) // R2
        else $error("locked write changed the timeout");
    chk_lock_store: assert property (wr_wd |=> timeout_write_lock_r == $past(reg_wdata[WD_LOCK_BIT])) // R2
        else $error("write-lock bit not stored");
    chk_timeout_load: assert property (wr_wd && !reg_wdata[WD_LOCK_BIT] // R4
        |=> timeout_ticks_r == $past(reg_wdata[WD_TICKS_MSB:0]))
        else $error("unlocked write did not store the timeout");
    chk_rdata_hold: assert property (!reg_rd_en |=> $stable(reg_rdata_r))
        else $error("read data moved without a read");

    // countdown: one step per tick, frozen in between
    chk_tick_step: assert property (tick && !watchdog_strobe && wd_count_r > CNT_ONE // R5
        |=> wd_count_r == $past(wd_count_r) - CNT_ONE)
        else $error("countdown did not step once per tick");
    chk_hold_between: assert property (!tick && !watchdog_strobe && wd_count_r != CNT_ZERO |=> $stable(wd_count_r)) // R5
        else $error("countdown moved between ticks");

    // flags: a write to the enables in the expiry cycle would legally hold the pin low
    chk_alarm_flag: assert property (alarm_match ##1 alarm_irq_enable |-> alarm_flag_r ##1 irq_out_r) // R6
        else $error("alarm did not reach flag and pin");
    chk_alarm_only: assert property (alarm_match |=> alarm_flag_r) // R6
        else $error("alarm flag not set");
    chk_pf_flag: assert property (powerfail_event |=> powerfail_flag_r) // R7
        else $error("power-fail flag not set");
    chk_pf_irq: assert property (powerfail_event ##1 powerfail_irq_enable |-> powerfail_flag_r ##1 irq_out_r) // R7
        else $error("power-fail did not reach flag and pin");
    chk_wd_masked: assert property (!watchdog_irq_enable && !(alarm_irq_enable && alarm_flag_r) // R8
        && !(powerfail_irq_enable && powerfail_flag_r) |=> !irq_out_r)
        else $error("interrupt pin driven without an enabled source");
    chk_wd_flag_gate: assert property (expire && !watchdog_irq_enable && !watchdog_flag_r |=> !watchdog_flag_r) // R8
        else $error("disabled expiry set the watchdog flag");
    chk_expiry_irq: assert property (expire && watchdog_irq_enable && !wr_ic // R8
        |=> watchdog_flag_r ##1 irq_out_r)
        else $error("enabled expiry did not drive the pin");

    // main scenarios the bench is expected to reach
    cov_strobe: cover property (watchdog_strobe && reg_wdata[WD_LOCK_BIT]);
    cov_expiry: cover property (expire ##2 irq_out_r);
    cov_alarm_irq: cover property (alarm_match && alarm_irq_enable ##2 irq_out_r);
    cov_set_on_clear: cover property (flags_clear && powerfail_event);
endmodule

// *** inc/rwd_pkg.sv ***
package rwd_pkg;
    // ----------------------------------------------------------------
    // register map, byte-wide registers at their printed offsets
    // ----------------------------------------------------------------
    localparam logic [3:0] REG_IRQ_CTRL = 4'h6;
    localparam logic [3:0] REG_WD_CTRL = 4'h7;
    localparam int REG_ADDR_W = 4;
    localparam int REG_DATA_W = 8;

    // watchdog_control fields
    localparam int WD_STROBE_BIT = 7;
    localparam int WD_LOCK_BIT = 6;
    localparam int WD_TICKS_MSB = 5;
    localparam int WD_TICKS_W = 6;

    // interrupt_status_control fields
    localparam int IC_WIE_BIT = 7;
    localparam int IC_AIE_BIT = 6;
    localparam int IC_PFE_BIT = 5;

    // reset values
    localparam logic [7:0] IRQ_CTRL_RST = 8'h00;
    localparam logic [5:0] WD_TICKS_RST = 6'h00;
    localparam logic WD_LOCK_RST = 1'b0;

    // ----------------------------------------------------------------
    // timing: one watchdog tick is one period of the 32 Hz count
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int WD_TICK_NS = 31_250_000;
    localparam int WD_TICK_CYCLES = WD_TICK_NS / CLK_PERIOD_NS;
endpackage

// *** verification/rwd_host_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// host side of the register port
// ----------------------------------------------------------------
module rwd_host_model
    import rwd_pkg::*;
(
    // clock
    input wire logic clk_sys,
    // register port
    output logic reg_wr_en,
    output logic reg_rd_en,
    output logic [REG_ADDR_W-1:0] reg_addr,
    output logic [REG_DATA_W-1:0] reg_wdata,
    input wire logic [REG_DATA_W-1:0] reg_rdata
);
    // idle bus at time zero
    initial begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
    end

    // one-cycle write strobe; data inverted after release so stale bytes never match
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr_en <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr_en <= 1'b0;
        reg_wdata <= ~d;
    endtask

    // read data is registered, so it is taken one cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_rd_en <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd_en <= 1'b0;
        @(posedge clk_sys);
        #1;
        d = reg_rdata;
    endtask
endmodule

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
module tb_top
    import rwd_pkg::*;
;
    // ----------------------------------------------------------------
    // clock, stimulus and wiring
    // ----------------------------------------------------------------
    localparam int TK = 4; // short tick keeps the run brief
    localparam int WD_T = 5 * TK; // a setting of five is five whole ticks after the strobe
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic alarm_match = 1'b0;
    logic powerfail_event = 1'b0;
    logic flags_clear = 1'b0;
    logic reg_wr_en, reg_rd_en, alarm_flag, powerfail_flag, watchdog_flag, irq_out;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rd_v;
    int n_errors = 0;
    int n_compared = 0;

    // 25 MHz clock
    always #20 clk_sys = ~clk_sys;

    rwd_host_model u_host (.clk_sys(clk_sys), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    rwd_watchdog_ctrl #(.TICK_CYCLES(TK)) u_dut (.clk_sys(clk_sys), .srst(srst),
        .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .alarm_match(alarm_match), .powerfail_event(powerfail_event),
        .flags_clear(flags_clear), .alarm_flag(alarm_flag), .powerfail_flag(powerfail_flag),
        .watchdog_flag(watchdog_flag), .irq_out(irq_out));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic end_sim;
        if (n_errors == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // bounded wait for expiry; irq must follow one cycle later
    task automatic wait_wd(input int exp);
        int n;
        n = 0;
        while (watchdog_flag !== 1'b1 && n < 200) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        chk(8'(n), 8'(exp));
        if (n >= 200) begin
            end_sim();
        end
        @(posedge clk_sys);
        #1;
        chk({7'h0, irq_out}, 8'h01);
    endtask

    task automatic clear_flags;
        @(posedge clk_sys);
        flags_clear <= 1'b1;
        @(posedge clk_sys);
        flags_clear <= 1'b0;
    endtask

    // one-cycle alarm (k=0) or power-fail (k=1) event, then settle two cycles
    task automatic fire(input int k);
        @(posedge clk_sys);
        alarm_match <= (k == 0);
        powerfail_event <= (k == 1);
        @(posedge clk_sys);
        alarm_match <= 1'b0;
        powerfail_event <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask

    // main sequence
    initial begin
        repeat (12) @(posedge clk_sys);
        srst <= 1'b0;
        u_host.rd(REG_IRQ_CTRL, rd_v);
        chk(rd_v, IRQ_CTRL_RST);
        u_host.rd(4'h3, rd_v);
        chk(rd_v, 8'h00);
        u_host.wr(REG_IRQ_CTRL, 8'h80);
        // strobe with the new timeout, so the free-running tick phase cannot skew the count
        u_host.wr(REG_WD_CTRL, 8'h85);
        wait_wd(WD_T);
        u_host.rd(REG_WD_CTRL, rd_v);
        chk(rd_v, 8'h05);
        clear_flags();
        repeat (8) @(posedge clk_sys);
        u_host.wr(REG_WD_CTRL, 8'hc0);
        wait_wd(WD_T);
        u_host.rd(REG_WD_CTRL, rd_v);
        chk(rd_v, 8'h45);
        u_host.wr(REG_IRQ_CTRL, 8'h1f);
        clear_flags();
        repeat (3 * 5 * TK) @(posedge clk_sys);
        #1;
        chk({6'h0, watchdog_flag, irq_out}, 8'h00);
        for (int en = 0; en < 2; en++) begin
            for (int k = 0; k < 2; k++) begin
                u_host.wr(REG_IRQ_CTRL, en == 0 ? 8'h00 : (k == 0 ? 8'h40 : 8'h20));
                clear_flags();
                fire(k);
                chk({6'h0, k == 0 ? alarm_flag : powerfail_flag, irq_out}, {6'h0, 1'b1, en == 1});
            end
        end
        // a power-fail in the very cycle of a clear must survive it
        @(posedge clk_sys);
        flags_clear <= 1'b1;
        powerfail_event <= 1'b1;
        @(posedge clk_sys);
        flags_clear <= 1'b0;
        powerfail_event <= 1'b0;
        @(posedge clk_sys);
        #1;
        chk({6'h0, alarm_flag, powerfail_flag}, 8'h01);
        end_sim();
    end
endmodule
